// ===== rtl/pcs_top.sv
`timescale 1ns/1ps
// How it works
// [RULE_01] Five states: idle, track, settle, digitise, clear
// [RULE_02] Auto mode: threshold crossing starts track
// [RULE_03] Gated mode: gate pulse starts track
// [RULE_04] Auto mode: first peak ends track
// [RULE_05] Gated mode: track while gate high
// [RULE_06] Settling lasts 2 us, peak held
// [RULE_07] Digitise 13-bit sample over 0.8 us
// [RULE_08] Clear discharges 2 us, back to idle
// [RULE_09] Pile-up before and during busy discards
// [RULE_10] Accepted results go to 64K buffer
// [RULE_11] One event counter, two time counters
// [RULE_12] Event counter runs only with bit 0
// [RULE_13] Clear or reset write zeroes counters
// [RULE_14] Write elapsed-low register snapshots all counters
// [RULE_15] Low reads bits 15..0, high 31..16
// [RULE_16] Time counters advance on 1 kHz tick
// [RULE_17] Elapsed counter runs with bit 0
// [RULE_18] Live counter needs bits 0 and 6
// [RULE_19] Auto mode: live counts idle, track, not full
// [RULE_20] Gated mode: live counts track, settle, not full
// [RULE_21] Bit 9 selects auto or gated trigger
// [RULE_22] Bit 8 enables pile-up rejection
// [RULE_23] Bit 6 enables storing conversions
// [RULE_24] Full flag sticky until reset or clear
// [RULE_25] Snapshots hold until next freeze write
// [RULE_26] Busy from digitisation start to idle
module pcs_top #(
  parameter int BUF_DEPTH = pcs_pkg::BUF_DEPTH_DEF,
  parameter int TICK_CYCLES = pcs_pkg::TICK_CYC,
  parameter logic [15:0] REVISION = 16'h0100 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire pcs_pkg::pcs_req_t req,
  output logic [15:0] rdData_r,
  output logic rdValid_r,
  // Sample readout
  input wire logic bufPop,
  output logic [pcs_pkg::ADC_W-1:0] bufData_r,
  output logic bufDataValid_r,
  // Analog front end
  input wire logic discrimAbove,
  input wire logic peakDetect,
  input wire logic gateIn,
  input wire logic pileUpRejectInput,
  input wire logic [pcs_pkg::ADC_W-1:0] adcData,
  output logic trackEn_r,
  output logic holdEn_r,
  output logic adcConvert_r,
  output logic clearCap_r,
  output logic busy_r,
  // Board status
  input wire logic usbHighSpeed,
  input wire logic flashBusy
);
  import pcs_pkg::*;

  localparam int AW = $clog2(BUF_DEPTH);
  localparam int CW = AW + 1;
  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] FULL_CNT = CW'(BUF_DEPTH);
  localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_CYC - 1);
  localparam logic [5:0] DIGIT_LAST = 6'(DIGIT_CYC - 1);
  localparam logic [5:0] CLEAR_LAST = 6'(CLEAR_CYC - 1);
  localparam int A_SETTLE = SETTLE_CYC;
  localparam int A_CLEAR = CLEAR_CYC;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  function automatic logic hit(input pcs_req_t r, input logic [8:0] ofs);
    hit = r.addr == ofs;
  endfunction : hit

  logic [15:0] control_r;
  logic [15:0] genReg_r [OFS_GEN_FIRST:OFS_GEN_LAST];
  wire wrControl = req.wr && hit(req, OFS_CONTROL);
  wire freezeWr = req.wr && hit(req, OFS_ELAP_LO);
  wire softClear = req.wr && hit(req, OFS_SOFT_CLEAR);
  wire softReset = req.wr && hit(req, OFS_SOFT_RESET);
  wire cntZero = softClear || softReset;
  wire runEn = control_r[CTL_RUN];
  wire autoMode = control_r[CTL_AUTO];
  wire storeEn = control_r[CTL_STORE];
  wire purEn = control_r[CTL_PUR_EN];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      control_r <= CONTROL_RST;
    end else if (wrControl) begin
      control_r <= req.wdata;
    end
  end

  genvar g;
  generate
    for (g = OFS_GEN_FIRST; g <= OFS_GEN_LAST; g++) begin : gGen
      // Trim set/clear are write-only strobes and keep no state
      if (g == OFS_TRIM_SET || g == OFS_TRIM_CLEAR) begin : gWo
        always_ff @(posedge clk_sys) begin
          genReg_r[g] <= GEN_RST;
        end
      end else begin : gRw
        always_ff @(posedge clk_sys) begin
          if (rst) begin
            genReg_r[g] <= GEN_RST;
          end else if (req.wr && hit(req, 9'(g))) begin
            genReg_r[g] <= req.wdata;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  pcs_state_t state_r;
  pcs_state_t state_nxt;
  logic [5:0] phaseCnt_r;
  logic [5:0] phaseCnt_nxt;
  logic rejectArm_r;
  logic reject_nxt;

  wire startAuto = autoMode && discrimAbove; // [RULE_02] [RULE_21]
  wire startGate = !autoMode && gateIn; // [RULE_03] [RULE_21]
  wire endAuto = autoMode && peakDetect; // [RULE_04]
  wire endGate = !autoMode && !gateIn; // [RULE_05]
  wire phaseDone = (state_r == ST_SETTLE && phaseCnt_r == SETTLE_LAST)
                || (state_r == ST_DIGIT && phaseCnt_r == DIGIT_LAST)
                || (state_r == ST_CLEAR && phaseCnt_r == CLEAR_LAST);

  always_comb begin // [RULE_01]
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (startAuto || startGate) state_nxt = ST_TRACK;
      ST_TRACK: if (endAuto || endGate) state_nxt = ST_SETTLE;
      ST_SETTLE: if (phaseDone) state_nxt = ST_DIGIT; // [RULE_06]
      ST_DIGIT: if (phaseDone) state_nxt = ST_CLEAR; // [RULE_07]
      ST_CLEAR: if (phaseDone) state_nxt = ST_IDLE; // [RULE_08]
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign phaseCnt_nxt = (state_nxt != state_r) ? 6'h00 : phaseCnt_r + 6'h01;

  // Pile-up must already be high as digitisation begins and stay high through it
  assign reject_nxt = (state_r == ST_SETTLE && state_nxt == ST_DIGIT)
                    ? (purEn && pileUpRejectInput)
                    : (rejectArm_r && pileUpRejectInput); // [RULE_09] [RULE_22]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_IDLE;
      phaseCnt_r <= 6'h00;
      rejectArm_r <= 1'b0;
      trackEn_r <= 1'b0;
      holdEn_r <= 1'b0;
      adcConvert_r <= 1'b0;
      clearCap_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phaseCnt_r <= phaseCnt_nxt;
      rejectArm_r <= reject_nxt;
      trackEn_r <= state_nxt == ST_TRACK;
      holdEn_r <= state_nxt == ST_SETTLE || state_nxt == ST_DIGIT; // [RULE_06]
      adcConvert_r <= state_nxt == ST_DIGIT; // [RULE_07]
      clearCap_r <= state_nxt == ST_CLEAR; // [RULE_08]
      busy_r <= state_nxt == ST_DIGIT || state_nxt == ST_CLEAR; // [RULE_26]
    end
  end

  // ----------------------------------------
  // Sample buffer
  // ----------------------------------------
  logic [ADC_W-1:0] mem_r [BUF_DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [CW-1:0] fill_r;
  logic fullFlag_r;

  wire convDone = state_r == ST_DIGIT && phaseDone; // [RULE_11]
  wire bufFull = fill_r == FULL_CNT;
  wire bufEmpty = fill_r == '0;
  wire doPush = convDone && storeEn && !rejectArm_r && !bufFull; // [RULE_10] [RULE_23] [RULE_09]
  wire doPop = bufPop && !bufEmpty;
  wire fillEvent = doPush && fill_r == FULL_CNT - CW'(1);
  wire flagClr = softReset || control_r[CTL_FLAG_CLEAR];

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem_r[wrPtr_r] <= adcData; // [RULE_10]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || softReset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      fill_r <= '0;
      bufData_r <= '0;
      bufDataValid_r <= 1'b0;
    end else begin
      wrPtr_r <= wrPtr_r + AW'(doPush);
      rdPtr_r <= rdPtr_r + AW'(doPop);
      fill_r <= fill_r + CW'(doPush) - CW'(doPop);
      bufData_r <= doPop ? mem_r[rdPtr_r] : bufData_r;
      bufDataValid_r <= doPop;
    end
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fullFlag_r <= 1'b0;
    end else if (fillEvent) begin
      fullFlag_r <= 1'b1; // [RULE_24]
    end else if (flagClr) begin
      fullFlag_r <= 1'b0; // [RULE_24]
    end
  end

  // ----------------------------------------
  // Counters and snapshots
  // ----------------------------------------
  logic [TW-1:0] tickCnt_r;
  logic tick_r;
  logic [31:0] evtCnt_r;
  logic [31:0] elapCnt_r;
  logic [31:0] liveCnt_r;
  logic [31:0] evtSnap_r;
  logic [31:0] elapSnap_r;
  logic [31:0] liveSnap_r;

  wire tickWrap = tickCnt_r == TW'(TICK_CYCLES - 1);
  wire liveAuto = state_r == ST_IDLE || state_r == ST_TRACK; // [RULE_19]
  wire liveGate = state_r == ST_TRACK || state_r == ST_SETTLE; // [RULE_20]
  wire liveOn = runEn && storeEn && !bufFull
             && (autoMode ? liveAuto : liveGate); // [RULE_18]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tickCnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tickCnt_r <= tickWrap ? '0 : tickCnt_r + TW'(1);
      tick_r <= tickWrap; // [RULE_16]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || cntZero) begin // [RULE_13]
      evtCnt_r <= 32'h0000_0000;
      elapCnt_r <= 32'h0000_0000;
      liveCnt_r <= 32'h0000_0000;
    end else begin
      evtCnt_r <= evtCnt_r + 32'(convDone && runEn); // [RULE_12]
      elapCnt_r <= elapCnt_r + 32'(tick_r && runEn); // [RULE_17]
      liveCnt_r <= liveCnt_r + 32'(tick_r && liveOn); // [RULE_18]
    end
  end

  // Snapshot keeps reads coherent while the live counters move on
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evtSnap_r <= 32'h0000_0000;
      elapSnap_r <= 32'h0000_0000;
      liveSnap_r <= 32'h0000_0000;
    end else if (freezeWr) begin // [RULE_14] [RULE_25]
      evtSnap_r <= evtCnt_r;
      elapSnap_r <= elapCnt_r;
      liveSnap_r <= liveCnt_r;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [15:0] status;
  logic [15:0] fillRead;
  logic [15:0] rdMux;
  logic genHit;

  assign fillRead = (fill_r > CW'(16'hFFFF)) ? 16'hFFFF : 16'(fill_r);
  assign genHit = req.addr >= OFS_GEN_FIRST && req.addr <= OFS_GEN_LAST;
  always_comb begin
    status = 16'h0000;
    status[STS_USB_HS] = usbHighSpeed;
    status[STS_EMPTY] = bufEmpty;
    status[STS_FULL] = fullFlag_r;
    status[STS_FLASH_BUSY] = flashBusy;
  end

  always_comb begin // [RULE_15]
    rdMux = 16'h0000;
    unique case (req.addr)
      OFS_STATUS: rdMux = status;
      OFS_CONTROL: rdMux = control_r;
      OFS_REVISION: rdMux = REVISION;
      OFS_FILL: rdMux = fillRead;
      OFS_EVT_LO: rdMux = evtSnap_r[15:0];
      OFS_EVT_HI: rdMux = evtSnap_r[31:16];
      OFS_ELAP_LO: rdMux = elapSnap_r[15:0];
      OFS_ELAP_HI: rdMux = elapSnap_r[31:16];
      OFS_LIVE_LO: rdMux = liveSnap_r[15:0];
      OFS_LIVE_HI: rdMux = liveSnap_r[31:16];
      default: rdMux = genHit ? genReg_r[req.addr[3:0]] : 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_r <= 16'h0000;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r <= req.rd ? rdMux : rdData_r;
      rdValid_r <= req.rd;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_settle_len;
    @(posedge clk_sys) disable iff (rst)
    $rose(holdEn_r) |-> !adcConvert_r [*8] ##42 !adcConvert_r ##1 adcConvert_r;
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle length wrong"); // [RULE_06]

  property p_digit_len;
    @(posedge clk_sys) disable iff (rst)
    $rose(adcConvert_r) |-> adcConvert_r [*8] ##12 adcConvert_r ##1 !adcConvert_r;
  endproperty
  a_digit_len: assert property (p_digit_len) else $error("digitise not 20 cycles"); // [RULE_07]

  property p_clear_idle;
    @(posedge clk_sys) disable iff (rst)
    $rose(clearCap_r) |-> ##[A_SETTLE:A_CLEAR] (!clearCap_r && state_r == ST_IDLE);
  endproperty
  a_clear_idle: assert property (p_clear_idle) else $error("clear not ending to idle"); // [RULE_08]

  property p_busy_span;
    @(posedge clk_sys) disable iff (rst)
    busy_r |-> (state_r == ST_DIGIT || state_r == ST_CLEAR);
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("busy outside conversion"); // [RULE_26]

  property p_auto_start;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_IDLE && autoMode && discrimAbove) |=> trackEn_r;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("no track on threshold"); // [RULE_02]

  property p_gate_track;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_TRACK && !autoMode && gateIn) |=> state_r == ST_TRACK;
  endproperty
  a_gate_track: assert property (p_gate_track) else $error("left track with gate high"); // [RULE_05]

  property p_reject;
    @(posedge clk_sys) disable iff (rst)
    (convDone && rejectArm_r) |=> $stable(wrPtr_r);
  endproperty
  a_reject: assert property (p_reject) else $error("piled-up event stored"); // [RULE_09]

  property p_evt_hold;
    @(posedge clk_sys) disable iff (rst)
    (!runEn && !cntZero) |=> $stable(evtCnt_r);
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event counter moved"); // [RULE_12]

  property p_zero;
    @(posedge clk_sys) disable iff (rst)
    cntZero |=> (evtCnt_r == 32'h0 && elapCnt_r == 32'h0 && liveCnt_r == 32'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("counters not zeroed"); // [RULE_13]

  property p_snap;
    @(posedge clk_sys) disable iff (rst)
    freezeWr |=> (elapSnap_r == $past(elapCnt_r) && liveSnap_r == $past(liveCnt_r));
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot mismatch"); // [RULE_14]

  property p_snap_hold;
    @(posedge clk_sys) disable iff (rst)
    !freezeWr |=> $stable(evtSnap_r);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("snapshot drifted"); // [RULE_25]

  property p_live_stop;
    @(posedge clk_sys) disable iff (rst)
    (!liveOn && !cntZero) |=> $stable(liveCnt_r);
  endproperty
  a_live_stop: assert property (p_live_stop) else $error("live counter ran"); // [RULE_19]

  property p_full_set;
    @(posedge clk_sys) disable iff (rst)
    fillEvent |=> fullFlag_r;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag not set"); // [RULE_24]
endmodule : pcs_top

// ===== inc/pcs_pkg.sv
package pcs_pkg;
  // ----------------------------------------
  // Register offsets (word index on the register port)
  // ----------------------------------------
  localparam logic [8:0] OFS_STATUS = 9'h000;
  localparam logic [8:0] OFS_CONTROL = 9'h001;
  localparam logic [8:0] OFS_REVISION = 9'h002;
  localparam logic [8:0] OFS_GEN_FIRST = 9'h003;
  localparam logic [8:0] OFS_TRIM_SET = 9'h009;
  localparam logic [8:0] OFS_TRIM_CLEAR = 9'h00A;
  localparam logic [8:0] OFS_GEN_LAST = 9'h00B;
  localparam logic [8:0] OFS_FILL = 9'h00C;
  localparam logic [8:0] OFS_EVT_LO = 9'h00D;
  localparam logic [8:0] OFS_EVT_HI = 9'h00E;
  localparam logic [8:0] OFS_ELAP_LO = 9'h00F;
  localparam logic [8:0] OFS_ELAP_HI = 9'h010;
  localparam logic [8:0] OFS_LIVE_LO = 9'h011;
  localparam logic [8:0] OFS_LIVE_HI = 9'h012;
  localparam logic [8:0] OFS_SOFT_CLEAR = 9'h013;
  localparam logic [8:0] OFS_SOFT_RESET = 9'h134;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_RUN = 0;
  localparam int CTL_FLAG_CLEAR = 5;
  localparam int CTL_STORE = 6;
  localparam int CTL_PUR_EN = 8;
  localparam int CTL_AUTO = 9;
  localparam int STS_USB_HS = 0;
  localparam int STS_EMPTY = 1;
  localparam int STS_FULL = 2;
  localparam int STS_FLASH_BUSY = 3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] GEN_RST = 16'h0000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 25;
  localparam real SETTLE_US = 2.0;
  localparam real DIGIT_US = 0.8;
  localparam real CLEAR_US = 2.0;
  localparam int TICK_PERIOD_US = 1000;
  localparam int SETTLE_CYC = int'(SETTLE_US * CLK_MHZ);
  localparam int DIGIT_CYC = int'(DIGIT_US * CLK_MHZ);
  localparam int CLEAR_CYC = int'(CLEAR_US * CLK_MHZ);
  localparam int TICK_CYC = TICK_PERIOD_US * CLK_MHZ;
  localparam int ADC_W = 13;
  localparam int BUF_DEPTH_DEF = 65536;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TRACK = 3'b001,
    ST_SETTLE = 3'b010,
    ST_DIGIT = 3'b011,
    ST_CLEAR = 3'b100
  } pcs_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [15:0] wdata;
  } pcs_req_t;
endpackage : pcs_pkg

// ===== rtl/pcs_unused_none.sv
`timescale 1ns/1ps

// ===== dv/pcs_afe_model.sv
`timescale 1ns/1ps
module pcs_afe_model #(
  parameter int RISE = 3
) (
  // Clock
  input wire logic clk_sys,
  // Bench control
  input wire logic fire,
  input wire logic [pcs_pkg::ADC_W-1:0] peakVal,
  // Sequencer side
  input wire logic trackEn,
  input wire logic adcConvert,
  output logic discrimAbove,
  output logic peakDetect,
  output logic [pcs_pkg::ADC_W-1:0] adcData
);
  import pcs_pkg::*;
  int riseCnt;
  // ----------------------------------------
  // Stretcher and converter
  // ----------------------------------------
  initial begin
    discrimAbove = 1'h0;
    riseCnt = 0;
    adcData = 13'h0AAA;
  end
  always @(posedge clk_sys) begin
    if (fire) begin
      discrimAbove <= 1'h1;
    end else if (adcConvert) begin
      discrimAbove <= 1'h0;
    end
    riseCnt <= trackEn ? riseCnt + 1 : 0;
    // Toggles off-conversion so a stale sample never looks right
    adcData <= adcConvert ? peakVal : ~adcData;
  end
  assign peakDetect = trackEn && riseCnt >= RISE;
endmodule : pcs_afe_model

// ===== dv/pcs_top_bench.sv
`timescale 1ns/1ps
module pcs_top_bench;
  import pcs_pkg::*;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  localparam int DEPTH = 4; // Small buffer so it fills quickly
  localparam int LIMIT = 20000;
  localparam logic [15:0] REV = 16'h0A5C; // Arbitrary value
  typedef struct packed {
    logic doWr;
    logic [8:0] addr;
    logic [15:0] data;
    logic [15:0] exp;
  } pcs_row_t;
  logic clk_sys, rst, bufPop, gateIn, pileUpRejectInput, fire, discrimAbove, peakDetect;
  logic rdValid_r, bufDataValid_r, trackEn_r, holdEn_r, adcConvert_r, clearCap_r, busy_r;
  logic [15:0] rdData_r;
  logic [12:0] bufData_r, adcData, peakVal;
  pcs_req_t req;
  wire logic [4:0] outs = {trackEn_r, holdEn_r, adcConvert_r, clearCap_r, busy_r};
  int nErrors = 0;
  int checksDone = 0;
  int cycles = 0;
  pcs_row_t rows [8] = '{
    '{1'h0, OFS_STATUS, 16'h0000, 16'h0003},
    '{1'h1, OFS_GEN_LAST, 16'hA5A5, 16'hA5A5},
    '{1'h1, OFS_GEN_FIRST, 16'h1234, 16'h1234},
    '{1'h1, OFS_REVISION, 16'hFFFF, REV},
    '{1'h1, OFS_TRIM_SET, 16'hFFFF, 16'h0000},
    '{1'h1, OFS_FILL, 16'hFFFF, 16'h0000},
    '{1'h0, 9'h020, 16'h0000, 16'h0000},
    '{1'h1, OFS_CONTROL, 16'h0341, 16'h0341}};
  pcs_top #(.BUF_DEPTH(DEPTH), .TICK_CYCLES(10), .REVISION(REV)) i_pcs_top (
    .clk_sys(clk_sys), .rst(rst), .req(req), .rdData_r(rdData_r), .rdValid_r(rdValid_r),
    .bufPop(bufPop), .bufData_r(bufData_r), .bufDataValid_r(bufDataValid_r),
    .discrimAbove(discrimAbove), .peakDetect(peakDetect), .gateIn(gateIn),
    .pileUpRejectInput(pileUpRejectInput), .adcData(adcData), .trackEn_r(trackEn_r),
    .holdEn_r(holdEn_r), .adcConvert_r(adcConvert_r), .clearCap_r(clearCap_r),
    .busy_r(busy_r), .usbHighSpeed(1'h1), .flashBusy(1'h0));
  pcs_afe_model i_pcs_afe_model (
    .clk_sys(clk_sys), .fire(fire), .peakVal(peakVal), .trackEn(trackEn_r),
    .adcConvert(adcConvert_r), .discrimAbove(discrimAbove), .peakDetect(peakDetect),
    .adcData(adcData));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude();
    if (nErrors == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic chkReg(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chkReg
  task automatic chkCnt(input string what, input int exp, input int got);
    checksDone++;
    if (got != exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chkCnt
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(negedge clk_sys);
    req.wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 16'h0000};
    @(negedge clk_sys);
    req.rd = 1'h0;
    chkReg("read valid", 32'h1, 32'(rdValid_r));
    d = rdData_r;
  endtask : rd
  task automatic snap(output logic [31:0] e, output logic [31:0] t, output logic [31:0] l);
    logic [15:0] lo, hi;
    wr(OFS_ELAP_LO, 16'h0000);
    rd(OFS_EVT_LO, lo);
    rd(OFS_EVT_HI, hi);
    e = {hi, lo};
    rd(OFS_ELAP_LO, lo);
    rd(OFS_ELAP_HI, hi);
    t = {hi, lo};
    rd(OFS_LIVE_LO, lo);
    rd(OFS_LIVE_HI, hi);
    l = {hi, lo};
  endtask : snap
  // Counts falling edges while one sequencer output stays at lvl
  task automatic hold(input int b, input logic lvl, output int n);
    n = 0;
    while (outs[b] === lvl && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : hold
  task automatic evt(input logic gated, input logic [12:0] v, input logic pile_up_reject_input);
    int n;
    peakVal = v;
    if (gated) begin
      gateIn = 1'h1;
    end else begin
      fire = 1'h1;
    end
    hold(4, 1'h0, n);
    fire = 1'h0;
    chkCnt("track start", gated ? 1 : 2, n);
    if (gated) begin
      repeat (4) @(negedge clk_sys);
      chkReg("gated track", 32'h2, 32'({trackEn_r, holdEn_r}));
      gateIn = 1'h0;
    end
    hold(3, 1'h0, n);
    chkReg("peak held", 32'h1, 32'(holdEn_r));
    pileUpRejectInput = pile_up_reject_input;
    hold(2, 1'h0, n);
    chkCnt("settle length", SETTLE_CYC, n);
    chkReg("digit outputs", 32'h0D, 32'(outs));
    hold(2, 1'h1, n);
    chkCnt("digit length", DIGIT_CYC, n);
    chkReg("clear outputs", 32'h03, 32'(outs));
    hold(1, 1'h1, n);
    chkCnt("clear length", CLEAR_CYC, n);
    chkReg("back to idle", 32'h00, 32'(outs));
    pileUpRejectInput = 1'h0;
  endtask : evt
  task automatic pop(input logic ok, input logic [12:0] v);
    @(negedge clk_sys);
    bufPop = 1'h1;
    @(negedge clk_sys);
    bufPop = 1'h0;
    chkReg("pop valid", 32'(ok), 32'(bufDataValid_r));
    if (ok) begin
      chkReg("pop data", 32'(v), 32'(bufData_r));
    end
  endtask : pop
  // ----------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      nErrors++;
      conclude();
    end
  end
  initial begin
    logic [31:0] e, t, l, e2, t2, l2;
    logic [15:0] d;
    rst = 1'h1;
    req = '0;
    bufPop = 1'h0;
    gateIn = 1'h0;
    pileUpRejectInput = 1'h0;
    fire = 1'h0;
    peakVal = 13'h0000;
    repeat (8) @(negedge clk_sys);
    rst = 1'h0;
    chkReg("reset outputs", 32'h0, 32'(outs));
    foreach (rows[i]) begin
      if (rows[i].doWr) begin
        wr(rows[i].addr, rows[i].data);
      end
      rd(rows[i].addr, d);
      chkReg("register", 32'(rows[i].exp), 32'(d));
    end
    repeat (40) @(negedge clk_sys);
    wr(OFS_CONTROL, 16'h0000);
    wr(OFS_SOFT_CLEAR, 16'h5A5A);
    repeat (50) @(negedge clk_sys);
    snap(e, t, l);
    chkReg("stopped counters", 32'h0, e | t | l);
    wr(OFS_CONTROL, 16'h0241);
    repeat (200) @(negedge clk_sys);
    snap(e, t, l);
    chkCnt("elapsed ticks", 1, int'(t >= 19 && t <= 21));
    chkReg("live in idle", t, l);
    repeat (30) @(negedge clk_sys);
    rd(OFS_ELAP_LO, d);
    chkReg("held snapshot", {16'h0, t[15:0]}, {16'h0, d});
    wr(OFS_CONTROL, 16'h0341);
    evt(1'h0, 13'h1ABC, 1'h0);
    evt(1'h0, 13'h0555, 1'h1);
    wr(OFS_CONTROL, 16'h0201);
    evt(1'h0, 13'h0999, 1'h0);
    wr(OFS_CONTROL, 16'h0240);
    evt(1'h0, 13'h0777, 1'h1);
    snap(e, t, l);
    chkReg("event count", 32'h3, e);
    rd(OFS_FILL, d);
    chkReg("fill level", 32'h2, 32'(d));
    pop(1'h1, 13'h1ABC);
    pop(1'h1, 13'h0777);
    pop(1'h0, 13'h0000);
    // Gated mode: live time only runs inside the event
    wr(OFS_CONTROL, 16'h0000);
    wr(OFS_SOFT_CLEAR, 16'h0000);
    wr(OFS_CONTROL, 16'h0041);
    repeat (100) @(negedge clk_sys);
    snap(e, t, l);
    chkCnt("gated idle live", 1, int'(l == 0 && t > 0));
    evt(1'h1, 13'h0123, 1'h0);
    snap(e2, t2, l2);
    chkCnt("gated event live", 1, int'(l2 >= 4 && l2 <= 7));
    pop(1'h1, 13'h0123);
    // Fill to the brim, one more event is lost
    wr(OFS_SOFT_RESET, 16'h0000);
    wr(OFS_CONTROL, 16'h0241);
    for (int i = 1; i <= DEPTH + 1; i++) begin
      evt(1'h0, 13'(i) * 13'h0111, 1'h0);
    end
    rd(OFS_STATUS, d);
    chkReg("full status", 32'h5, 32'(d));
    rd(OFS_FILL, d);
    chkCnt("full fill", DEPTH, int'(d));
    snap(e, t, l);
    repeat (50) @(negedge clk_sys);
    snap(e2, t2, l2);
    chkReg("live when full", l, l2);
    chkCnt("elapsed when full", 1, int'(t2 > t));
    for (int i = 1; i <= DEPTH; i++) begin
      pop(1'h1, 13'(i) * 13'h0111);
    end
    pop(1'h0, 13'h0000);
    rd(OFS_STATUS, d);
    chkReg("sticky full", 32'h7, 32'(d));
    wr(OFS_CONTROL, 16'h0261);
    wr(OFS_CONTROL, 16'h0241);
    rd(OFS_STATUS, d);
    chkReg("full cleared", 32'h3, 32'(d));
    conclude();
  end
endmodule : pcs_top_bench
